// ===== alfc_list_flow.sv
// Purpose: list buffering, start sequence, flow control and interrupts
// Assumes: conversion engine reports each stored result as conv_i.done
// Notes: one clock, synchronous active low reset, no register bus
`timescale 1ns/100ps
`default_nettype none
`include "alfc_cfg.svh"
module alfc_list_flow (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic soft_reset_i,
	input wire logic trigger_mode_i,
	input wire logic [1:0] flow_access_config_i,
	input wire logic command_list_buffer_mode_i,
	input wire logic result_list_buffer_mode_i,
	input wire alfc_pkg::alfc_flow_type bus_flow_i,
	input wire alfc_pkg::alfc_flow_type int_flow_i,
	input wire alfc_pkg::alfc_conv_type conv_i,
	input wire alfc_pkg::alfc_err_type err_event_i,
	input wire logic [15:0] conv_int_enable_i,
	input wire logic abort_int_enable_i,
	input wire logic [7:0] err_int_enable_i,
	input wire logic [15:0] conv_flag_clear_i,
	input wire logic abort_flag_clear_i,
	input wire logic [7:0] err_flag_clear_i,
	output logic powered_o,
	output logic running_o,
	output logic halted_o,
	output logic start_conv_o,
	output logic load_command_o,
	output logic command_list_select_o,
	output logic result_list_select_o,
	output logic [`ALFC_IDX_W-1:0] command_index_o,
	output logic [`ALFC_IDX_W-1:0] result_index_o,
	output alfc_pkg::alfc_flow_type flow_bits_o,
	output logic [15:0] conv_flags_o,
	output logic abort_done_flag_o,
	output alfc_pkg::alfc_err_type err_flags_o,
	output logic [1:0] intermediate_result_info_o,
	output logic [1:0] end_of_list_result_info_o,
	output logic conv_irq_o,
	output logic abort_irq_o,
	output logic err_irq_o,
	output logic machine_exception_o
);
	import alfc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_WAIT, ST_CONV}
		alfc_state_type;

	alfc_state_type state_r, state_nxt;
	alfc_flow_type flow_r;
	alfc_err_type err_r;
	logic [15:0] conv_flags_r;
	logic abort_done_r;
	logic cmd_sel_r, res_sel_r, res_swap_pend_r;
	logic [`ALFC_IDX_W-1:0] cidx_r, ridx_r;
	logic [1:0] imd_info_r, eol_info_r;

	// flow requests gated by the access field
	wire bus_ok = flow_access_config_i[0];
	wire int_ok = flow_access_config_i[1];
	wire req_sequence_abort_bit = (bus_ok & bus_flow_i.seq_abort) |
		(int_ok & int_flow_i.seq_abort);
	wire req_trigger_bit = (bus_ok & bus_flow_i.trigger) |
		(int_ok & int_flow_i.trigger);
	wire req_restart_request_bit = (bus_ok & bus_flow_i.restart) |
		(int_ok & int_flow_i.restart);
	wire req_load_ok_bit = (bus_ok & bus_flow_i.load_ok) |
		(int_ok & int_flow_i.load_ok);

	// severe errors and memory fault halt: state and flow bits clear, list selects and indices hold
	wire halt = err_r.illegal_list_access_error |
		err_r.invalid_command_error | err_r.end_of_list_error |
		err_r.trigger_overrun_error | err_r.double_bit_memory_error;
	wire active = enable_i & ~halt;
	wire busy = (state_r == ST_CONV);
	wire is_eol = conv_i.done & (conv_i.kind == `ALFC_CMD_EOL);
	wire is_eos = conv_i.done & (conv_i.kind == `ALFC_CMD_EOS);
	// abort completes at the conversion boundary
	wire abort_done = flow_r.seq_abort & (~busy | conv_i.done);
	wire list_end = is_eol | abort_done;
	// restart while busy aborts first and flags it
	wire restart_request_bit_unexp = req_restart_request_bit & busy & ~flow_r.seq_abort & ~req_sequence_abort_bit;
	// trigger while a restart or an earlier trigger is still pending is an overrun
	wire trigger_bit_ovr = req_trigger_bit & (flow_r.trigger | flow_r.restart);
	// restart events only execute while not converting and with no abort pending
	wire do_restart = active & flow_r.restart & ~busy & ~flow_r.seq_abort;
	// list one is only reachable in double mode
	wire cmd_swap = do_restart & flow_r.load_ok & command_list_buffer_mode_i;
	wire auto_trigger_bit = do_restart & trigger_mode_i;
	wire start = active & flow_r.trigger & (state_r == ST_WAIT);
	wire load_ok_bit_bad = req_load_ok_bit & ~req_restart_request_bit;
	wire [3:0] fsel = conv_i.flag_sel;
	wire [15:0] conv_set = (conv_i.done & active & (fsel != 4'h0)) ?
		(16'h0001 << fsel) : 16'h0000;
	wire [15:0] eol_set = is_eol & active ? 16'h0001 : 16'h0000;
	wire [15:0] conv_new = conv_set | eol_set;
	wire conv_ovr = |(conv_new & conv_flags_r);
	alfc_err_type err_set;

	always_comb begin
		err_set = err_event_i;
		err_set.trigger_overrun_error = err_event_i.trigger_overrun_error |
			(active & trigger_bit_ovr);
		err_set.unexpected_restart_error =
			err_event_i.unexpected_restart_error | (active & restart_request_bit_unexp);
		err_set.load_ok_error = err_event_i.load_ok_error |
			(active & load_ok_bit_bad & ~trigger_mode_i);
		err_set.conversion_flag_overflow =
			err_event_i.conversion_flag_overflow | conv_ovr;
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (do_restart) begin
					state_nxt = ST_LOAD;
				end
			end
			ST_LOAD: begin
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (start) begin
					state_nxt = ST_CONV;
				end else if (do_restart) begin
					state_nxt = ST_LOAD;
				end
			end
			ST_CONV: begin
				if (abort_done) begin
					state_nxt = ST_IDLE;
				end else if (is_eol) begin
					// trigger mode wraps to top, restart mode idles
					state_nxt = trigger_mode_i ? ST_WAIT : ST_IDLE;
				end else if (is_eos) begin
					state_nxt = ST_WAIT;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// state and flow bits; soft reset restores operation
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i || soft_reset_i || !active) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i || soft_reset_i || !active) begin
			flow_r <= '0;
		end else begin
			flow_r.seq_abort <= (flow_r.seq_abort & ~abort_done) |
				req_sequence_abort_bit | restart_request_bit_unexp;
			// restart and load-ok clear once the first command loads
			flow_r.restart <= (flow_r.restart & ~do_restart) |
				req_restart_request_bit;
			flow_r.load_ok <= (flow_r.load_ok & ~do_restart) |
				(req_load_ok_bit & req_restart_request_bit);
			flow_r.trigger <= (flow_r.trigger & ~start) | req_trigger_bit |
				auto_trigger_bit;
		end
	end

	// list selection and indices
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i || soft_reset_i) begin
			cmd_sel_r <= 1'b0;
			res_sel_r <= 1'b0;
			res_swap_pend_r <= 1'b0;
			cidx_r <= `ALFC_IDX_TOP;
			ridx_r <= `ALFC_IDX_TOP;
		end else if (active) begin
			if (cmd_swap) begin
				cmd_sel_r <= ~cmd_sel_r;
			end
			// result swap is deferred to the first new result
			if (list_end) begin
				res_swap_pend_r <= 1'b1;
			end else if (conv_i.done && res_swap_pend_r) begin
				res_swap_pend_r <= 1'b0;
				res_sel_r <= ~res_sel_r;
			end
			if (do_restart || list_end) begin
				cidx_r <= `ALFC_IDX_TOP;
				ridx_r <= `ALFC_IDX_TOP;
			end else if (conv_i.done) begin
				cidx_r <= cidx_r + `ALFC_IDX_ONE;
				ridx_r <= ridx_r + `ALFC_IDX_ONE;
			end
		end
	end

	// sticky flags: a set in the clear cycle wins
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			conv_flags_r <= '0;
			abort_done_r <= 1'b0;
			err_r <= '0;
			imd_info_r <= 2'h0;
			eol_info_r <= 2'h0;
		end else begin
			conv_flags_r <= (conv_flags_r & ~conv_flag_clear_i) |
				conv_new;
			abort_done_r <= (abort_done_r & ~abort_flag_clear_i) |
				(active & abort_done);
			if (soft_reset_i) begin
				err_r <= '0;
			end else begin
				err_r <= (err_r & ~err_flag_clear_i) | err_set;
			end
			if (|conv_set) begin
				imd_info_r <= {cmd_sel_r, res_sel_r};
			end
			if (|eol_set) begin
				eol_info_r <= {cmd_sel_r, res_sel_r};
			end
		end
	end

	logic [7:0] err_vec;
	assign err_vec = err_r;
	assign powered_o = enable_i;
	assign running_o = busy;
	assign halted_o = halt;
	assign start_conv_o = start;
	assign load_command_o = (state_r == ST_LOAD);
	assign command_list_select_o = cmd_sel_r & command_list_buffer_mode_i;
	assign result_list_select_o = res_sel_r & result_list_buffer_mode_i;
	assign command_index_o = cidx_r;
	assign result_index_o = ridx_r;
	assign flow_bits_o = flow_r;
	assign conv_flags_o = conv_flags_r;
	assign abort_done_flag_o = abort_done_r;
	assign err_flags_o = err_r;
	assign intermediate_result_info_o = imd_info_r;
	assign end_of_list_result_info_o = eol_info_r;
	assign conv_irq_o = |(conv_flags_r & conv_int_enable_i);
	assign abort_irq_o = abort_done_r & abort_int_enable_i;
	// memory fault bit 3 excluded from the interrupt
	assign err_irq_o = |(err_vec & err_int_enable_i & ~`ALFC_ERR_DBE);
	assign machine_exception_o = err_r.double_bit_memory_error;

	a_halt_stops: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		halt |-> !start_conv_o ##1 (!running_o && !load_command_o))
		else $error("conversion started while halted");
	a_soft_clear: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i) soft_reset_i |=> !halted_o)
		else $error("soft reset left converter halted");
	a_dbe_no_irq: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		err_r.double_bit_memory_error |-> machine_exception_o && halt &&
		(err_vec != `ALFC_ERR_DBE || !err_irq_o))
		else $error("memory fault not escalated");
	a_sel_forced: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		!command_list_buffer_mode_i |-> !command_list_select_o)
		else $error("command select not forced low");
	sequence s_restart_load;
		do_restart ##1 load_command_o;
	endsequence
	a_restart_idx: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i || soft_reset_i)
		s_restart_load |-> command_index_o == `ALFC_IDX_TOP &&
		!flow_bits_o.restart && !flow_bits_o.load_ok)
		else $error("restart did not reset list state");
	a_auto_trigger_bit: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i || soft_reset_i)
		auto_trigger_bit && active |=> flow_bits_o.trigger)
		else $error("trigger mode restart gave no trigger");
	a_cmd_swap: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i || soft_reset_i)
		do_restart && !flow_r.load_ok |=> $stable(cmd_sel_r))
		else $error("command list swapped without load-ok");
	a_eol_flag: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		is_eol && active |=> conv_flags_o[`ALFC_EOL_BIT])
		else $error("end-of-list flag not set");
	a_info_upd: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		|conv_set |=> imd_info_r == $past({cmd_sel_r, res_sel_r}))
		else $error("intermediate info not updated");
endmodule : alfc_list_flow
`default_nettype wire

// ===== alfc_cfg.svh
// Purpose: constants for the list flow and interrupt control block
// Assumes: included by the package and the design module
// Notes: widths and encodings only
`ifndef ALFC_CFG_SVH
`define ALFC_CFG_SVH
`define ALFC_ACC_BUS 2'h1
`define ALFC_ACC_INT 2'h2
`define ALFC_ACC_BOTH 2'h3
`define ALFC_CONV_FLAGS 16
`define ALFC_EOL_BIT 0
`define ALFC_ERR_DBE 8'h08
`define ALFC_IDX_W 8
`define ALFC_IDX_TOP 8'h00
`define ALFC_IDX_ONE 8'h01
`define ALFC_CMD_W 2
`define ALFC_CMD_NORM 2'h0
`define ALFC_CMD_EOS 2'h1
`define ALFC_CMD_EOL 2'h2
`define ALFC_CMD_BAD 2'h3
`endif

// ===== alfc_pkg.sv
// Purpose: types for the list flow and interrupt control block
// Assumes: alfc_cfg.svh holds the numbers
// Notes: flow request bundle and error flag bundle
`default_nettype none
`include "alfc_cfg.svh"
package alfc_pkg;
	typedef struct packed {
		logic seq_abort;
		logic trigger;
		logic restart;
		logic load_ok;
	} alfc_flow_type;
	typedef struct packed {
		logic illegal_list_access_error;
		logic invalid_command_error;
		logic end_of_list_error;
		logic trigger_overrun_error;
		logic double_bit_memory_error;
		logic unexpected_restart_error;
		logic load_ok_error;
		logic conversion_flag_overflow;
	} alfc_err_type;
	typedef struct packed {
		logic done;
		logic [`ALFC_CMD_W-1:0] kind;
		logic [3:0] flag_sel;
	} alfc_conv_type;
endpackage : alfc_pkg
`default_nettype wire

// ===== alfc_int_model.sv
// Purpose: model of the internal flow control side of the converter
// Assumes: the bench names the request; it lasts one clock
// Notes: requests change only just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module alfc_int_model (
	input wire logic clk_sys_i,
	input wire alfc_pkg::alfc_flow_type send_i,
	output alfc_pkg::alfc_flow_type int_flow_o
);
	import alfc_pkg::*;
	// the request bundle is forwarded as sent, one clock late; load-ok alone is not blocked
	always_ff @(posedge clk_sys_i) begin
		int_flow_o <= send_i;
	end
endmodule : alfc_int_model
`default_nettype wire

// ===== adc_list_flow_and_interrupts_test.sv
// Purpose: self-checking bench for the list flow control block
// Assumes: internal flow side is modelled by alfc_int_model
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
`include "alfc_cfg.svh"
module adc_list_flow_and_interrupts_test;
	import alfc_pkg::*;
	localparam alfc_flow_type RS = 4'h2, RL = 4'h3, TR = 4'h4, AB = 4'h8;
	logic clk = 0, rst_n = 0, en = 0, srst = 0, tm = 1, cbm = 0, rbm = 0;
	logic [1:0] acc = 2'h3;
	alfc_flow_type bf = '0, ir = '0, itf, fb;
	alfc_conv_type cv = '0;
	alfc_err_type ev = '0, ef;
	logic [15:0] cen = 16'hffff, cclr = '0, cf;
	logic [7:0] een = 8'hff, eclr = '0, cidx, ridx;
	logic aclr = 0, aen = 1, ab, pw, run, hlt, sc, lc, csel, rsel, ci, ai;
	logic ei, mx;
	logic [1:0] imi, eoi;
	int fails = 0, cmp_count = 0, cyc = 0;
	alfc_list_flow i_alfc_list_flow (.clk_sys_i(clk), .reset_n_i(rst_n),
		.enable_i(en), .soft_reset_i(srst), .trigger_mode_i(tm),
		.flow_access_config_i(acc), .command_list_buffer_mode_i(cbm),
		.result_list_buffer_mode_i(rbm), .bus_flow_i(bf),
		.int_flow_i(itf), .conv_i(cv), .err_event_i(ev),
		.conv_int_enable_i(cen), .abort_int_enable_i(aen),
		.err_int_enable_i(een), .conv_flag_clear_i(cclr),
		.abort_flag_clear_i(aclr), .err_flag_clear_i(eclr),
		.powered_o(pw), .running_o(run), .halted_o(hlt),
		.start_conv_o(sc), .load_command_o(lc),
		.command_list_select_o(csel), .result_list_select_o(rsel),
		.command_index_o(cidx), .result_index_o(ridx), .flow_bits_o(fb),
		.conv_flags_o(cf), .abort_done_flag_o(ab), .err_flags_o(ef),
		.intermediate_result_info_o(imi),
		.end_of_list_result_info_o(eoi), .conv_irq_o(ci),
		.abort_irq_o(ai), .err_irq_o(ei), .machine_exception_o(mx));
	alfc_int_model i_alfc_int_model (.clk_sys_i(clk), .send_i(ir),
		.int_flow_o(itf));
	always #50 clk = ~clk;
	// the whole run needs under a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			final_report();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task final_report();
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task pulse(input bit b, input alfc_flow_type f);
		@(negedge clk);
		if (b) ir = f;
		else bf = f;
		@(negedge clk);
		ir = '0;
		bf = '0;
	endtask : pulse
	task conv(input logic [1:0] kd, input logic [3:0] fs);
		@(negedge clk);
		cv = {1'b1, kd, fs};
		@(negedge clk);
		cv = '0;
	endtask : conv
	task sreset();
		srst = 1;
		eclr = 8'hff;
		@(negedge clk);
		srst = 0;
		eclr = '0;
		@(negedge clk);
	endtask : sreset
	// bounded wait: 0 load, 1 start, 2 abort done
	task await(input int w);
		int k;
		for (k = 0; k < 10; k++) begin
			if ((w == 0 ? lc : w == 1 ? sc : ab) === 1'b1) break;
			@(negedge clk);
		end
		if (k == 10) begin
			fails++;
			$display("ERROR %0t: wait %0d timed out", $time, w);
		end
	endtask : await
	task s_reset();
		chk({pw, run, hlt, csel, rsel}, 0);
		chk({ef, cf}, 0);
		rst_n = 1;
		en = 1;
		@(negedge clk);
		chk(pw, 1);
	endtask : s_reset
	task s_start();
		acc = 2'h1;
		pulse(1, RS);
		tick(3);
		chk(fb, 0);
		acc = 2'h3;
		pulse(0, RS); // list zero filled beforehand
		await(0);
		chk({fb.restart, fb.load_ok, cidx, ridx}, 0);
		chk(fb.trigger, 1);
		await(1);
		chk(sc, 1);
		@(negedge clk);
		chk(run, 1);
	endtask : s_start
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task s_conv();
		conv(`ALFC_CMD_NORM, 4'h3);
		chk({cf, ci}, 17'h00011);
		cen = 16'h0000;
		@(negedge clk);
		chk(ci, 0);
		cen = 16'hffff;
		conv(`ALFC_CMD_NORM, 4'h3);
		chk({ef, hlt, ei}, 10'h005);
		cclr = 16'h0008;
		@(negedge clk);
		cclr = '0;
		chk(cf, 0);
		conv(`ALFC_CMD_EOL, 4'h0);
		chk(cf, 16'h0001);
		tick(2);
		chk({cidx, ridx, eoi}, 0);
	endtask : s_conv
	task s_abort();
		pulse(0, TR);
		await(1);
		pulse(0, AB);
		conv(`ALFC_CMD_NORM, 4'h0);
		await(2);
		chk({ab, ai}, 2'h3);
		aen = 0;
		tick(2);
		chk({cidx, ridx, ai}, 0);
		aen = 1;
		aclr = 1;
		@(negedge clk);
		aclr = 0;
		chk(ab, 0);
	endtask : s_abort
	// severe flags halt; double-bit goes to the exception, not the irq
	task s_err();
		int i;
		for (i = 0; i < 8; i++) begin
			ev = alfc_err_type'(8'h01 << i);
			@(negedge clk);
			ev = '0;
			chk({hlt, ei, mx}, {i > 2, i != 3, i == 3});
			sreset();
			chk({ef, hlt, mx}, 0);
		end
	endtask : s_err
	task s_overrun();
		tm = 0;
		@(negedge clk);
		bf = RS;
		@(negedge clk);
		// trigger lands while the restart bit is still set
		bf = TR;
		@(negedge clk);
		bf = '0;
		chk({ef.trigger_overrun_error, hlt, ei}, 3'h7);
		een = '0;
		pulse(0, RS);
		tick(3);
		chk({fb.restart, ei}, 0);
		een = 8'hff;
		sreset();
		chk(hlt, 0);
	endtask : s_overrun
	task s_swap();
		cbm = 1;
		rbm = 1;
		pulse(0, RL);
		await(0);
		chk(csel, 1);
		pulse(0, RS);
		await(0);
		chk(csel, 1);
		pulse(1, RL);
		await(0);
		chk(csel, 0);
		pulse(0, RL);
		await(0);
		pulse(0, TR);
		conv(`ALFC_CMD_EOL, 4'h0);
		chk(eoi, 2'h2);
		pulse(0, RS);
		pulse(0, TR);
		// two-entry lists stay inside the result area
		conv(`ALFC_CMD_NORM, 4'h1);
		conv(`ALFC_CMD_NORM, 4'h2);
		chk({rsel, imi}, 3'h7);
		cbm = 0;
		rbm = 0;
		#1 chk({csel, rsel}, 0);
	endtask : s_swap
	initial begin
		tick(4);
		s_reset();
		s_start();
		s_conv();
		s_abort();
		s_err();
		s_overrun();
		s_swap();
		final_report();
	end
endmodule : adc_list_flow_and_interrupts_test
`default_nettype wire
